// *** drive_sup_pkg.sv ***
// Constants, register map and state type for the drive supervisor
package drive_sup_pkg;
  // Clock and tick timing
  localparam int unsigned CLK_PERIOD_NS = 50;
  localparam int unsigned MS_TICK_NS    = 1_000_000;
  localparam int unsigned MS_CYCLES     = MS_TICK_NS / CLK_PERIOD_NS;
  localparam int unsigned MS_PER_S      = 1000;
  localparam int unsigned DISP_TO_S     = 90;
  // Scaling
  localparam int unsigned PCT_FULL      = 100;
  localparam int unsigned LEGACY_FS     = 10000;
  localparam int unsigned METER_SRCS    = 18;
  localparam int unsigned METERS        = 4;
  localparam int unsigned SKIPS         = 4;
  // Register byte addresses
  localparam logic [7:0] ADDR_CTRL    = 8'h00;
  localparam logic [7:0] ADDR_USP_PCT = 8'h04;
  localparam logic [7:0] ADDR_USP_MS  = 8'h08;
  localparam logic [7:0] ADDR_FBL_PCT = 8'h0c;
  localparam logic [7:0] ADDR_FBL_MS  = 8'h10;
  localparam logic [7:0] ADDR_GAIN    = 8'h14;
  localparam logic [7:0] ADDR_SKIP12  = 8'h18;
  localparam logic [7:0] ADDR_SKIP34  = 8'h1c;
  localparam logic [7:0] ADDR_BAND    = 8'h20;
  localparam logic [7:0] ADDR_METER   = 8'h24;
  localparam logic [7:0] ADDR_RDLY    = 8'h28;
  localparam logic [7:0] ADDR_RCFG    = 8'h2c;
  localparam logic [7:0] ADDR_CMD     = 8'h30;
  localparam logic [7:0] ADDR_STATUS  = 8'h34;
  // Control bit positions
  localparam int unsigned CB_MENU_DATA = 0;
  localparam int unsigned CB_ACC_ALL   = 1;
  localparam int unsigned CB_DISP_TO   = 2;
  localparam int unsigned CB_KP_PORT   = 3;
  localparam int unsigned CB_REM_PORT  = 4;
  localparam int unsigned CB_LEGACY    = 5;
  localparam int unsigned CB_DATA_TX   = 6;
  localparam int unsigned CB_PARAM_TX  = 7;
  localparam int unsigned CB_ALT_FMT   = 8;
  localparam int unsigned CB_PWR_RST   = 9;
  localparam int unsigned CB_FLT_RST   = 10;
  localparam int unsigned CMD_CLR_BIT  = 0;
  // Reset values
  localparam logic [10:0] CTRL_RST  = 11'h001;
  localparam logic [15:0] PCT_RST   = 16'h0064;
  localparam logic [15:0] MS_RST    = 16'h07d0;
  localparam logic [15:0] GAIN_RST  = 16'h0028;
  localparam logic [19:0] METER_RST = 20'h18820;
  localparam logic [31:0] RDLY_RST  = 32'h000a_000a;
  localparam logic [23:0] RCFG_RST  = 24'h003c03;
  // Fault codes
  localparam logic [1:0] FLT_NONE = 2'h0;
  localparam logic [1:0] FLT_USP  = 2'h1;
  localparam logic [1:0] FLT_FBL  = 2'h2;
  localparam logic [1:0] FLT_EXT  = 2'h3;
  typedef enum logic [2:0] {
    ST_PWR_WAIT = 3'h0, ST_RUN = 3'h1, ST_FAULT = 3'h3, ST_FLT_WAIT = 3'h2,
    ST_LOCKED = 3'h6, ST_STOP = 3'h4
  } sup_state_t;
endpackage : drive_sup_pkg

// *** trip_timer.sv ***
// Millisecond persistence timer that qualifies one fault condition
`timescale 1ns/10ps
module trip_timer (
  // Clock and reset
  input  wire logic        hclk,
  input  wire logic        hresetn,
  // Timing
  input  wire logic        ms_tick,
  input  wire logic [15:0] limit_ms,
  // Condition and trip
  input  wire logic        cond,
  output logic             trip
);
  logic [15:0] cnt_r;

  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      cnt_r <= 16'h0000;
      trip  <= 1'b0;
    end else if (!cond) begin
      cnt_r <= 16'h0000;
      trip  <= 1'b0;
    end else begin
      if (ms_tick && cnt_r < limit_ms) cnt_r <= cnt_r + 16'h0001;
      trip <= (cnt_r >= limit_ms);
    end
  end

  default clocking cb @(posedge hclk); endclocking
  default disable iff (!hresetn);

  a_timer_restart: assert property (!cond |=> cnt_r == 16'h0000 && !trip)
    else $error("trip timer not restarted when condition dropped");
  a_timer_early: assert property ($rose(trip) |-> $past(cnt_r) >= $past(limit_ms))
    else $error("trip raised before programmed time");
endmodule : trip_timer

// *** skip_band.sv ***
// Moves a setpoint out of any of the skip speed bands
`timescale 1ns/10ps
module skip_band (
  // Setpoint in
  input  wire logic [15:0] sp_in,
  // Skip speeds and shared band
  input  wire logic [15:0] skip_rpm [drive_sup_pkg::SKIPS],
  input  wire logic [15:0] band,
  // Setpoint out
  output logic      [15:0] sp_out
);
  logic [drive_sup_pkg::SKIPS-1:0] hit;
  logic [15:0]                     alt [drive_sup_pkg::SKIPS];

  for (genvar i = 0; i < drive_sup_pkg::SKIPS; i++) begin : g_skip
    wire [16:0] lo = (skip_rpm[i] > band) ? {1'b0, skip_rpm[i] - band} : 17'h00000;
    wire [16:0] hi = {1'b0, skip_rpm[i]} + {1'b0, band};
    assign hit[i] = ({1'b0, sp_in} > lo) && ({1'b0, sp_in} < hi);
    assign alt[i] = (sp_in < skip_rpm[i]) ? lo[15:0] :
                    (hi[16] ? 16'hffff : hi[15:0]);
  end

  // Lowest numbered band wins
  always_comb begin
    sp_out = sp_in;
    for (int j = drive_sup_pkg::SKIPS - 1; j >= 0; j--) begin
      if (hit[j]) sp_out = alt[j];
    end
  end
endmodule : skip_band

// *** drive_fault_restart_supervisor.sv ***
// Drive fault qualification, phase back, skip bands, meters, serial gating, restart
// Operation
// - Underspeed when shortfall exceeds span percentage
// - Underspeed trips after programmed persistence time
// - Feedback loss: no feedback, current reaches percentage
// - Feedback loss trips after programmed time
// - Overload phase back scaled by proportional gain
// - Overload phase back adds integral term
// - Setpoints kept out of skip bands
// - Four meters, each selects one quantity
// - Menu data transmit off when option disabled
// - Access all opens every menu
// - Blank keypad display after 90 s idle
// - Keypad and remote each routed to port
// - Legacy option scales link values to 10000
// - Data transmit sends operating data unsolicited
// - Parameter transmit sends changed parameters
// - Format select picks alternate or native format
// - Power restart runs if start circuit closed
// - Power restart waits programmed delay
// - Fault restart after programmed delay
// - Restart attempts limited to programmed maximum
// - Attempt count cleared after continuous run time
// - Clear clears fault, else fault history
`timescale 1ns/10ps
module drive_fault_restart_supervisor #(
  parameter int unsigned MS_CYCLES = drive_sup_pkg::MS_CYCLES
) (
  // Clock and reset
  input  wire logic        hclk,
  input  wire logic        hresetn,
  // AHB-Lite slave
  input  wire logic        hsel,
  input  wire logic [31:0] haddr,
  input  wire logic [1:0]  htrans,
  input  wire logic        hwrite,
  input  wire logic [2:0]  hsize,
  input  wire logic [31:0] hwdata,
  input  wire logic        hready,
  output logic             hreadyout,
  output logic             hresp,
  output logic      [31:0] hrdata,
  // Pins from the field
  input  wire logic        start_closed,
  input  wire logic        plc_run_closed,
  input  wire logic        fb_present,
  input  wire logic        key_press,
  // Drive quantities
  input  wire logic [15:0] speed_cmd,
  input  wire logic [15:0] speed_meas,
  input  wire logic [15:0] speed_span,
  input  wire logic [15:0] clutch_amps,
  input  wire logic [15:0] amps_limit,
  input  wire logic [15:0] setpoint_in,
  input  wire logic        ext_fault,
  input  wire logic [15:0] meter_qty [drive_sup_pkg::METER_SRCS],
  // Serial sources
  input  wire logic        kp_txd,
  input  wire logic        rem_txd,
  // Drive commands
  output logic             run_cmd,
  output logic             fault_active,
  output logic      [15:0] ol_reduce,
  output logic      [15:0] setpoint_out,
  output logic      [15:0] meter_out [drive_sup_pkg::METERS],
  // Serial side
  output logic             port1_txd,
  output logic             port2_txd,
  output logic             disp_blank,
  output logic             menu_tx_en,
  output logic             menus_all_open,
  output logic             data_tx_en,
  output logic             param_tx_pulse,
  output logic             alt_format,
  output logic      [15:0] link_speed
);
  // Registers
  logic [10:0] ctrl_r;
  logic [15:0] usp_pct_r, usp_ms_r, fbl_pct_r, fbl_ms_r, gain_r, band_r;
  logic [31:0] skip12_r, skip34_r, rdly_r;
  logic [19:0] meter_r;
  logic [23:0] rcfg_r;
  logic        wr_pend_r;
  logic [7:0]  waddr_r;
  // Synchronisers
  logic [1:0]  start_sy, plc_sy, fb_sy, key_sy;
  // Ticks, faults, restart
  logic [15:0] ms_cnt_r;
  logic [9:0]  sec_cnt_r;
  logic        ms_tick, sec_tick;
  logic [1:0]  cur_fault_r;
  logic [7:0]  hist_r;
  logic [7:0]  retry_r;
  logic [15:0] dly_sec_r, run_sec_r;
  logic [6:0]  disp_cnt_r;
  logic [31:0] integ_r;
  logic        under_trip, fbl_trip;
  logic [15:0] sp_skip;
  drive_sup_pkg::sup_state_t state_r, state_nxt;

  // Bus decode
  wire addr_ok  = hsel && htrans[1] && hready;
  wire [7:0] ra = haddr[7:0];
  wire wr_ctrl  = wr_pend_r && waddr_r == drive_sup_pkg::ADDR_CTRL;
  wire wr_cmd   = wr_pend_r && waddr_r == drive_sup_pkg::ADDR_CMD;
  wire wr_param = wr_pend_r && waddr_r < drive_sup_pkg::ADDR_CMD;
  wire clr_cmd  = wr_cmd && hwdata[drive_sup_pkg::CMD_CLR_BIT];
  wire [31:0] status = {9'h000, disp_blank, run_cmd, state_r, retry_r, hist_r, cur_fault_r};
  wire [31:0] rd_mux =
    (ra == drive_sup_pkg::ADDR_CTRL)    ? {21'h000000, ctrl_r} :
    (ra == drive_sup_pkg::ADDR_USP_PCT) ? {16'h0000, usp_pct_r} :
    (ra == drive_sup_pkg::ADDR_USP_MS)  ? {16'h0000, usp_ms_r} :
    (ra == drive_sup_pkg::ADDR_FBL_PCT) ? {16'h0000, fbl_pct_r} :
    (ra == drive_sup_pkg::ADDR_FBL_MS)  ? {16'h0000, fbl_ms_r} :
    (ra == drive_sup_pkg::ADDR_GAIN)    ? {16'h0000, gain_r} :
    (ra == drive_sup_pkg::ADDR_SKIP12)  ? skip12_r :
    (ra == drive_sup_pkg::ADDR_SKIP34)  ? skip34_r :
    (ra == drive_sup_pkg::ADDR_BAND)    ? {16'h0000, band_r} :
    (ra == drive_sup_pkg::ADDR_METER)   ? {12'h000, meter_r} :
    (ra == drive_sup_pkg::ADDR_RDLY)    ? rdly_r :
    (ra == drive_sup_pkg::ADDR_RCFG)    ? {8'h00, rcfg_r} :
    (ra == drive_sup_pkg::ADDR_STATUS)  ? status : 32'h0000_0000;

  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      wr_pend_r <= 1'b0;
      waddr_r   <= 8'h00;
      hrdata    <= 32'h0000_0000;
      hreadyout <= 1'b0;
      hresp     <= 1'b0;
    end else begin
      hreadyout <= 1'b1;
      wr_pend_r <= addr_ok && hwrite;
      if (addr_ok) waddr_r <= ra;
      if (addr_ok && !hwrite) hrdata <= rd_mux;
    end
  end

  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      ctrl_r    <= drive_sup_pkg::CTRL_RST;
      usp_pct_r <= drive_sup_pkg::PCT_RST;
      usp_ms_r  <= drive_sup_pkg::MS_RST;
      fbl_pct_r <= drive_sup_pkg::PCT_RST;
      fbl_ms_r  <= drive_sup_pkg::MS_RST;
      gain_r    <= drive_sup_pkg::GAIN_RST;
      skip12_r  <= 32'h0000_0000;
      skip34_r  <= 32'h0000_0000;
      band_r    <= 16'h0000;
      meter_r   <= drive_sup_pkg::METER_RST;
      rdly_r    <= drive_sup_pkg::RDLY_RST;
      rcfg_r    <= drive_sup_pkg::RCFG_RST;
    end else if (wr_pend_r) begin
      unique case (waddr_r)
        drive_sup_pkg::ADDR_CTRL:    ctrl_r    <= hwdata[10:0];
        drive_sup_pkg::ADDR_USP_PCT: usp_pct_r <= hwdata[15:0];
        drive_sup_pkg::ADDR_USP_MS:  usp_ms_r  <= hwdata[15:0];
        drive_sup_pkg::ADDR_FBL_PCT: fbl_pct_r <= hwdata[15:0];
        drive_sup_pkg::ADDR_FBL_MS:  fbl_ms_r  <= hwdata[15:0];
        drive_sup_pkg::ADDR_GAIN:    gain_r    <= hwdata[15:0];
        drive_sup_pkg::ADDR_SKIP12:  skip12_r  <= hwdata;
        drive_sup_pkg::ADDR_SKIP34:  skip34_r  <= hwdata;
        drive_sup_pkg::ADDR_BAND:    band_r    <= hwdata[15:0];
        drive_sup_pkg::ADDR_METER:   meter_r   <= hwdata[19:0];
        drive_sup_pkg::ADDR_RDLY:    rdly_r    <= hwdata;
        drive_sup_pkg::ADDR_RCFG:    rcfg_r    <= hwdata[23:0];
        default: ;
      endcase
    end
  end

  // Pin synchronisers
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      start_sy <= 2'h0;
      plc_sy   <= 2'h0;
      fb_sy    <= 2'h0;
      key_sy   <= 2'h0;
    end else begin
      start_sy <= {start_sy[0], start_closed};
      plc_sy   <= {plc_sy[0], plc_run_closed};
      fb_sy    <= {fb_sy[0], fb_present};
      key_sy   <= {key_sy[0], key_press};
    end
  end

  // Millisecond and second enables
  assign ms_tick  = ms_cnt_r == 16'(MS_CYCLES - 1);
  assign sec_tick = ms_tick && sec_cnt_r == 10'(drive_sup_pkg::MS_PER_S - 1);
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      ms_cnt_r  <= 16'h0000;
      sec_cnt_r <= 10'h000;
    end else begin
      ms_cnt_r <= ms_tick ? 16'h0000 : ms_cnt_r + 16'h0001;
      if (ms_tick) sec_cnt_r <= sec_tick ? 10'h000 : sec_cnt_r + 10'h001;
    end
  end

  // Fault conditions in percent of span or limit
  wire [31:0] pct_k     = 32'(drive_sup_pkg::PCT_FULL);
  wire [31:0] short_amt = (speed_cmd > speed_meas) ? 32'(speed_cmd - speed_meas) : 32'h0;
  wire under_cond = short_amt * pct_k > 32'(usp_pct_r) * 32'(speed_span);
  wire fbl_cond   = !fb_sy[1] &&
                    32'(clutch_amps) * pct_k >= 32'(fbl_pct_r) * 32'(amps_limit);

  trip_timer u_usp_tmr (
    .hclk     (hclk),
    .hresetn  (hresetn),
    .ms_tick  (ms_tick),
    .limit_ms (usp_ms_r),
    .cond     (under_cond),
    .trip     (under_trip)
  );
  trip_timer u_fbl_tmr (
    .hclk     (hclk),
    .hresetn  (hresetn),
    .ms_tick  (ms_tick),
    .limit_ms (fbl_ms_r),
    .cond     (fbl_cond),
    .trip     (fbl_trip)
  );

  // Overload phase back
  wire        ovr    = clutch_amps > amps_limit;
  wire [31:0] err    = ovr ? 32'(clutch_amps - amps_limit) : 32'h0;
  wire [31:0] p_term = err * 32'(gain_r[7:0]) / pct_k;
  wire [31:0] i_step = err * 32'(gain_r[15:8]) / pct_k;
  wire [31:0] red    = ovr ? p_term + integ_r : 32'h0;
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      integ_r   <= 32'h0;
      ol_reduce <= 16'h0000;
    end else begin
      if (!ovr) integ_r <= 32'h0;
      else if (ms_tick && integ_r < 32'h0000_ffff) integ_r <= integ_r + i_step;
      ol_reduce <= (red > 32'h0000_ffff) ? 16'hffff : red[15:0];
    end
  end

  logic [15:0] skip_arr [drive_sup_pkg::SKIPS];
  assign skip_arr[0] = skip12_r[15:0];
  assign skip_arr[1] = skip12_r[31:16];
  assign skip_arr[2] = skip34_r[15:0];
  assign skip_arr[3] = skip34_r[31:16];
  skip_band u_skip (
    .sp_in    (setpoint_in),
    .skip_rpm (skip_arr),
    .band     (band_r),
    .sp_out   (sp_skip)
  );

  // Meters
  for (genvar m = 0; m < drive_sup_pkg::METERS; m++) begin : g_meter
    wire [4:0] msel = meter_r[5*m +: 5];
    always_ff @(posedge hclk or negedge hresetn) begin
      if (!hresetn) meter_out[m] <= 16'h0000;
      else meter_out[m] <= (msel < 5'(drive_sup_pkg::METER_SRCS)) ?
                           meter_qty[msel] : 16'h0000;
    end
  end

  // Restart sequencing
  wire start_ok = start_sy[1] || plc_sy[1];
  wire fault_on = cur_fault_r != drive_sup_pkg::FLT_NONE;
  wire trip_any = under_trip || fbl_trip || ext_fault;
  wire [1:0] trip_code = under_trip ? drive_sup_pkg::FLT_USP :
                         fbl_trip ? drive_sup_pkg::FLT_FBL : drive_sup_pkg::FLT_EXT;
  wire [15:0] pwr_dly = rdly_r[15:0];
  wire [15:0] flt_dly = rdly_r[31:16];
  wire [7:0]  max_try = rcfg_r[7:0];
  wire [15:0] run_lim = rcfg_r[23:8];
  wire auto_go  = state_r == drive_sup_pkg::ST_FLT_WAIT && dly_sec_r >= flt_dly;
  wire fclr     = clr_cmd || auto_go;

  always_comb begin
    state_nxt = state_r;
    unique case (state_r)
      drive_sup_pkg::ST_PWR_WAIT:
        if (fault_on) state_nxt = drive_sup_pkg::ST_FAULT;
        else if (dly_sec_r >= pwr_dly) begin
          state_nxt = (ctrl_r[drive_sup_pkg::CB_PWR_RST] && start_ok) ?
                      drive_sup_pkg::ST_RUN : drive_sup_pkg::ST_STOP;
        end
      drive_sup_pkg::ST_RUN:
        if (fault_on) state_nxt = drive_sup_pkg::ST_FAULT;
        else if (!start_ok) state_nxt = drive_sup_pkg::ST_STOP;
      drive_sup_pkg::ST_FAULT:
        if (!fault_on) state_nxt = drive_sup_pkg::ST_STOP;
        else if (ctrl_r[drive_sup_pkg::CB_FLT_RST] && retry_r >= max_try)
          state_nxt = drive_sup_pkg::ST_LOCKED;
        else if (ctrl_r[drive_sup_pkg::CB_FLT_RST] && start_ok)
          state_nxt = drive_sup_pkg::ST_FLT_WAIT;
      drive_sup_pkg::ST_FLT_WAIT:
        if (clr_cmd) state_nxt = drive_sup_pkg::ST_STOP;
        else if (auto_go) state_nxt = drive_sup_pkg::ST_RUN;
      drive_sup_pkg::ST_LOCKED:
        if (!fault_on) state_nxt = drive_sup_pkg::ST_STOP;
      drive_sup_pkg::ST_STOP:
        if (fault_on) state_nxt = drive_sup_pkg::ST_FAULT;
        else if (start_ok) state_nxt = drive_sup_pkg::ST_RUN;
      default: state_nxt = drive_sup_pkg::ST_STOP;
    endcase
  end

  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      state_r   <= drive_sup_pkg::ST_PWR_WAIT;
      run_cmd   <= 1'b0;
      dly_sec_r <= 16'h0000;
      run_sec_r <= 16'h0000;
      retry_r   <= 8'h00;
    end else begin
      state_r <= state_nxt;
      run_cmd <= state_nxt == drive_sup_pkg::ST_RUN;
      if (state_nxt != state_r) dly_sec_r <= 16'h0000;
      else if (sec_tick && dly_sec_r != 16'hffff) dly_sec_r <= dly_sec_r + 16'h0001;
      if (state_r != drive_sup_pkg::ST_RUN) run_sec_r <= 16'h0000;
      else if (sec_tick && run_sec_r != 16'hffff) run_sec_r <= run_sec_r + 16'h0001;
      if (auto_go) retry_r <= retry_r + 8'h01;
      else if (state_r == drive_sup_pkg::ST_RUN && run_sec_r >= run_lim)
        retry_r <= 8'h00;
    end
  end

  // Current fault and history, a new trip wins over a clear
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      cur_fault_r  <= drive_sup_pkg::FLT_NONE;
      hist_r       <= 8'h00;
      fault_active <= 1'b0;
    end else begin
      if (fclr && fault_on) hist_r <= {hist_r[5:0], cur_fault_r};
      else if (clr_cmd) hist_r <= 8'h00;
      if (trip_any && (!fault_on || fclr)) cur_fault_r <= trip_code;
      else if (fclr) cur_fault_r <= drive_sup_pkg::FLT_NONE;
      fault_active <= trip_any || (fault_on && !fclr);
    end
  end

  // Display timeout and serial routing
  wire kp_blank_nxt = ctrl_r[drive_sup_pkg::CB_DISP_TO] &&
                      disp_cnt_r >= 7'(drive_sup_pkg::DISP_TO_S);
  wire kp_line  = kp_blank_nxt ? 1'b1 : kp_txd;
  wire kp_on2   = ctrl_r[drive_sup_pkg::CB_KP_PORT];
  wire rem_on2  = ctrl_r[drive_sup_pkg::CB_REM_PORT];
  wire lg_en    = ctrl_r[drive_sup_pkg::CB_LEGACY];
  wire [31:0] lg_val = 32'(speed_meas) * 32'(drive_sup_pkg::LEGACY_FS) / 32'h0001_0000;
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      disp_cnt_r     <= 7'h00;
      disp_blank     <= 1'b0;
      port1_txd      <= 1'b1;
      port2_txd      <= 1'b1;
      menu_tx_en     <= 1'b0;
      menus_all_open <= 1'b0;
      data_tx_en     <= 1'b0;
      param_tx_pulse <= 1'b0;
      alt_format     <= 1'b0;
      link_speed     <= 16'h0000;
      setpoint_out   <= 16'h0000;
    end else begin
      if (key_sy[1]) disp_cnt_r <= 7'h00;
      else if (sec_tick && !kp_blank_nxt) disp_cnt_r <= disp_cnt_r + 7'h01;
      disp_blank <= kp_blank_nxt;
      port1_txd  <= (!kp_on2 ? kp_line : 1'b1) & (!rem_on2 ? rem_txd : 1'b1);
      port2_txd  <= (kp_on2 ? kp_line : 1'b1) & (rem_on2 ? rem_txd : 1'b1);
      menu_tx_en     <= ctrl_r[drive_sup_pkg::CB_MENU_DATA];
      menus_all_open <= ctrl_r[drive_sup_pkg::CB_ACC_ALL];
      data_tx_en     <= ctrl_r[drive_sup_pkg::CB_DATA_TX];
      param_tx_pulse <= wr_param && ctrl_r[drive_sup_pkg::CB_PARAM_TX];
      alt_format     <= ctrl_r[drive_sup_pkg::CB_ALT_FMT];
      link_speed     <= lg_en ? lg_val[15:0] : speed_meas;
      setpoint_out   <= sp_skip;
    end
  end

  default clocking cb @(posedge hclk); endclocking
  default disable iff (!hresetn);

  sequence s_fault_wait_done;
    state_r == drive_sup_pkg::ST_FLT_WAIT ##1 state_r == drive_sup_pkg::ST_RUN;
  endsequence

  a_under_cause: assert property ($rose(under_trip) |-> $past(under_cond, 1))
    else $error("underspeed trip without shortfall");
  a_fbl_cause: assert property ($rose(fbl_trip) |-> $past(fb_sy[1], 1) == 1'b0)
    else $error("feedback loss trip with feedback present");
  a_ol_idle: assert property (!ovr ##1 !ovr |-> ol_reduce == 16'h0000)
    else $error("phase back active without overload");
  a_flt_delay: assert property (s_fault_wait_done |-> $past(dly_sec_r) >= $past(flt_dly))
    else $error("fault restart before delay");
  a_retry_count: assert property (s_fault_wait_done |-> retry_r == $past(retry_r) + 8'h01)
    else $error("restart attempt not counted");
  a_locked_stop: assert property (state_r == drive_sup_pkg::ST_LOCKED |=> !run_cmd)
    else $error("run while locked out");
  a_pwr_start: assert property ($rose(run_cmd) && $past(state_r) == drive_sup_pkg::ST_PWR_WAIT
                                |-> $past(ctrl_r[drive_sup_pkg::CB_PWR_RST]) && $past(start_ok))
    else $error("power restart without enable or start circuit");
  a_clear_hist: assert property (clr_cmd && !fault_on && !trip_any |=> hist_r == 8'h00)
    else $error("history not cleared");
  a_blank_key: assert property (key_sy[1] |=> ##1 !disp_blank)
    else $error("display blank after key press");
endmodule : drive_fault_restart_supervisor

// *** serial_host_model.sv ***
// Keypad and remote host model driving idle-high serial lines
`timescale 1ns/10ps
module serial_host_model (
  // Clock
  input  wire logic hclk,
  // Serial and keypad lines
  output logic      kp_txd,
  output logic      rem_txd,
  output logic      key_press
);
  logic [7:0] cnt_r = 8'h00;
  // Frames of alternating bits, idle high between them
  always @(posedge hclk) begin
    cnt_r     <= cnt_r + 8'h01;
    rem_txd   <= cnt_r[7] | cnt_r[0];
    kp_txd    <= cnt_r[6] | cnt_r[1];
    key_press <= (cnt_r == 8'h80);
  end
endmodule : serial_host_model

// *** testbench.sv ***
// Self-checking bench for the drive supervisor
`timescale 1ns/10ps
module testbench;
  logic hclk = 0, hresetn = 0, hsel = 0, hwrite = 0, hreadyout, hresp;
  logic [1:0] htrans = 2'h0;
  logic [31:0] haddr = 32'h0, hwdata = 32'h0, hrdata, d, rs = 32'h95ad00e7;
  logic [15:0] cmd = 0, meas = 0, span = 16'h01f4, amps = 0, lim = 16'h0064, sp = 0;
  logic [15:0] mq [drive_sup_pkg::METER_SRCS];
  logic [15:0] mo [drive_sup_pkg::METERS];
  logic kp, rem, key, run, flt, mtx, mall, dtx, ptx, alt, p1, p2, blank;
  logic st = 0, fb = 1, pline;
  logic [15:0] olr, spo, lsp;
  int fails = 0, n_compared = 0, npulse = 0;
  always #25 hclk = ~hclk;
  serial_host_model serial_host_model_i (.hclk(hclk), .kp_txd(kp), .rem_txd(rem), .key_press(key));
  drive_fault_restart_supervisor #(.MS_CYCLES(20)) drive_fault_restart_supervisor_i (
    .hclk(hclk), .hresetn(hresetn), .hsel(hsel), .haddr(haddr), .htrans(htrans),
    .hwrite(hwrite), .hsize(3'h2), .hwdata(hwdata), .hready(hreadyout),
    .hreadyout(hreadyout), .hresp(hresp), .hrdata(hrdata), .start_closed(st),
    .plc_run_closed(1'b0), .fb_present(fb), .key_press(key), .speed_cmd(cmd),
    .speed_meas(meas), .speed_span(span), .clutch_amps(amps), .amps_limit(lim),
    .setpoint_in(sp), .ext_fault(1'b0), .meter_qty(mq), .kp_txd(kp), .rem_txd(rem),
    .run_cmd(run), .fault_active(flt), .ol_reduce(olr), .setpoint_out(spo),
    .meter_out(mo), .port1_txd(p1), .port2_txd(p2), .disp_blank(blank),
    .menu_tx_en(mtx), .menus_all_open(mall), .data_tx_en(dtx),
    .param_tx_pulse(ptx), .alt_format(alt), .link_speed(lsp));
  always @(posedge hclk) if (ptx === 1'b1) npulse++;
  always @(posedge hclk) pline <= kp & rem;
  function automatic logic [15:0] skip_exp(input logic [15:0] s, input logic [63:0] k,
                                           input logic [15:0] b);
    logic [16:0] lo, hi;
    logic [15:0] kj, r;
    r = s;
    for (int j = 3; j >= 0; j--) begin
      kj = k[16*j +: 16];
      lo = (kj > b) ? {1'b0, kj - b} : 17'h00000;
      hi = {1'b0, kj} + {1'b0, b};
      if (s > lo && s < hi) r = (s < kj) ? lo[15:0] : (hi[16] ? 16'hffff : hi[15:0]);
    end
    return r;
  endfunction : skip_exp
  function automatic logic [31:0] lfsr(input logic [31:0] s);
    return {s[30:0], s[31] ^ s[21] ^ s[1] ^ s[0]};
  endfunction : lfsr
  task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
    n_compared++;
    if (seen !== exp) begin
      fails++;
      $display("[FAIL] %0t seen %h exp %h", $time, seen, exp);
    end
  endtask : chk
  task automatic xfer(input logic w, input logic [7:0] a, input logic [31:0] wd);
    hsel <= 1; htrans <= 2'h2; hwrite <= w; haddr <= {24'h0, a};
    do @(posedge hclk); while (hreadyout !== 1'b1);
    htrans <= 2'h0; hwdata <= wd;
    do @(posedge hclk); while (hreadyout !== 1'b1);
    d = hrdata;
  endtask : xfer
  task automatic ms(input int n);
    repeat (n * 20) @(posedge hclk);
  endtask : ms
  task automatic final_report;
    $display("compared %0d fails %0d", n_compared, fails);
    if (fails == 0 && n_compared > 0) $display("verification passed");
    else $display("verification failed");
    $finish;
  endtask : final_report
  initial begin
    #3_000_000;
    fails++;
    final_report;
  end
  initial begin
    for (int i = 0; i < drive_sup_pkg::METER_SRCS; i++) begin
      rs = lfsr(rs);
      mq[i] = rs[15:0];
    end
    repeat (8) @(posedge hclk);
    hresetn <= 1;
    repeat (2) @(posedge hclk);
    xfer(0, drive_sup_pkg::ADDR_CTRL, 0); chk(d, {21'h0, drive_sup_pkg::CTRL_RST});
    xfer(0, drive_sup_pkg::ADDR_GAIN, 0); chk(d, {16'h0, drive_sup_pkg::GAIN_RST});
    xfer(0, drive_sup_pkg::ADDR_USP_MS, 0); chk(d, {16'h0, drive_sup_pkg::MS_RST});
    xfer(0, drive_sup_pkg::ADDR_RCFG, 0); chk(d, {8'h0, drive_sup_pkg::RCFG_RST});
    xfer(0, drive_sup_pkg::ADDR_RDLY, 0); chk(d, drive_sup_pkg::RDLY_RST);
    xfer(0, 8'h3c, 0); chk(d, 0);
    xfer(1, drive_sup_pkg::ADDR_CTRL, 32'h1e2);
    rs = lfsr(rs); meas <= rs[15:0]; sp <= rs[25:16] % 900;
    xfer(1, drive_sup_pkg::ADDR_METER, 32'h18825);
    xfer(1, drive_sup_pkg::ADDR_SKIP12, 32'd1000);
    xfer(1, drive_sup_pkg::ADDR_BAND, 32'd50);
    repeat (3) @(posedge hclk);
    chk({mtx, mall, dtx, alt}, 4'h7);
    chk(lsp, (32'(meas) * 10000) >> 16);
    chk(mo[0], mq[5]);
    chk(spo, skip_exp(sp, 64'd1000, 16'd50));
    chk({p1, p2}, {pline, 1'b1});
    sp <= 16'd1010;
    xfer(1, drive_sup_pkg::ADDR_USP_MS, 32'd5);
    repeat (3) @(posedge hclk);
    chk(spo, 16'd1050);
    chk(npulse, 4);
    cmd <= 16'd1000; meas <= 0;
    ms(3); meas <= 16'd1000; ms(1); meas <= 0; ms(3);
    chk(flt, 0);
    ms(5);
    chk(flt, 1);
    xfer(0, drive_sup_pkg::ADDR_STATUS, 0); chk(d[1:0], drive_sup_pkg::FLT_USP);
    meas <= 16'd1000;
    xfer(1, drive_sup_pkg::ADDR_CMD, 32'h1);
    repeat (4) @(posedge hclk);
    chk(flt, 0);
    xfer(0, drive_sup_pkg::ADDR_STATUS, 0); chk(d[9:2], 8'h01);
    xfer(1, drive_sup_pkg::ADDR_CMD, 32'h1);
    @(posedge hclk);
    xfer(0, drive_sup_pkg::ADDR_STATUS, 0); chk(d[9:2], 8'h00);
    xfer(1, drive_sup_pkg::ADDR_FBL_MS, 32'd3);
    xfer(1, drive_sup_pkg::ADDR_RDLY, 32'h0);
    fb <= 0; amps <= 16'd150;
    ms(1);
    chk(flt, 0);
    ms(5);
    chk(olr, 16'd20);
    chk(flt, 1);
    xfer(0, drive_sup_pkg::ADDR_STATUS, 0); chk(d[1:0], drive_sup_pkg::FLT_FBL);
    st <= 1;
    xfer(1, drive_sup_pkg::ADDR_CTRL, 32'h5e2);
    repeat (20) @(posedge hclk);
    chk(run, 0);
    xfer(0, drive_sup_pkg::ADDR_STATUS, 0); chk(d[21:10], {1'b0, 3'h6, 8'h03});
    final_report;
  end
endmodule : testbench
